// file: hw/tmirq_pkg.sv
// constants, register map and types for the timer interrupt/status block
// Contract
// RULE1: writing one to enable-set bit 1 sets the capture-overrun enable
// RULE2: writing one to enable-set bit 0 sets the wrap enable
// RULE3: writing one to enable-set bits 5,4 sets channel enables
// RULE4: enable-clear write-one clears; both views read the shared enables
// RULE5: flag register at 0x0e, bits 5,4,3,1,0, reset zero
// RULE6: channel flag set after match or valid capture; irq when enabled
// RULE7: write one clears channel flag; capture register read clears too
// RULE8: capture on channel with flag set sets overrun, capture not stored
// RULE9: writing one to the overrun flag clears it
// RULE10: wrap flag set cycle after wrap; irq when wrap enable set
// RULE11: writing one to the wrap flag clears it
// RULE12: sync-ready flag set when synchronization ends; write one clears
// RULE13: status resets 0x08; bit 7 high while synchronization runs
// RULE14: status bit 4 high on upper unit while lower unit is 32-bit
// RULE15: status bit 3 high while stopped; set on disable, stop, single run
// RULE16: count register at 0x10, 8/16/32 bits by mode, reset zero
// RULE17: count access crosses domains via sync; writes obey write guard (code: only writes go through sync; reads register live_count directly)
// RULE18: period resets 0xff, loads from shadow on update, writes synced
package tmirq_pkg;
  localparam int AW = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_EN_CLR = 8'h0c;
  localparam logic [7:0] OFS_EN_SET = 8'h0d;
  localparam logic [7:0] OFS_FLAGS = 8'h0e;
  localparam logic [7:0] OFS_STATUS = 8'h0f;
  localparam logic [7:0] OFS_TALLY = 8'h10;
  localparam logic [7:0] OFS_CYCLE = 8'h14;
  // interrupt bit positions, shared by enables and flags
  localparam int B_WRAP = 0;
  localparam int B_OVRN = 1;
  localparam int B_SRDY = 3;
  localparam int B_CH0 = 4;
  localparam int B_CH1 = 5;
  localparam logic [7:0] IRQ_MASK = 8'h3b;
  // status bit positions
  localparam int S_STOP = 3;
  localparam int S_UPPER32 = 4;
  localparam int S_BUSY = 7;
  // control register fields
  localparam int C_ENABLE = 0;
  localparam int C_MODE_LO = 1;
  localparam int C_SINGLE = 3;
  localparam int C_CAP0 = 4;
  localparam int C_CAP1 = 5;
  // command register bits
  localparam int K_START = 0;
  localparam int K_STOP = 1;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_EN = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h08;
  localparam logic [31:0] RST_TALLY = 32'h0000_0000;
  localparam logic [7:0] RST_CYCLE = 8'hff;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [1:0] MODE_16 = 2'h0;
  localparam logic [1:0] MODE_8 = 2'h1;
  localparam logic [1:0] MODE_32 = 2'h2;
  localparam int SYNC_CYCLES = 4;
  typedef enum logic [1:0] {
    TMIRQ_IDLE = 2'b00,
    TMIRQ_SYNC = 2'b01
  } tmirq_sync_t;
endpackage : tmirq_pkg

// file: hw/tmirq_top.sv
// interrupt, status, count and period registers of one timer unit
//
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
module tmirq_top #(
  parameter int SYNC_LEN = tmirq_pkg::SYNC_CYCLES,
  parameter bit IS_UPPER = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [31:0] rdata,
  input wire logic write_guard,
  input wire logic [1:0] match_hit,
  input wire logic [1:0] capture_hit,
  input wire logic [1:0] capture_read,
  input wire logic wrap_hit,
  input wire logic [31:0] live_count,
  input wire logic lower_is_32,
  output logic [1:0] capture_store,
  output logic counter_run,
  output logic [1:0] counter_mode,
  output logic [7:0] cycle_length,
  output logic tally_load,
  output logic [31:0] tally_load_value,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [7:0] enables;
    logic [7:0] flags;
    logic [7:0] ctrl;
    logic halted;
    tmirq_pkg::tmirq_sync_t sync_state;
    logic [7:0] sync_cnt;
    logic pend_tally;
    logic pend_cycle;
    logic [31:0] tally_wr;
    logic [31:0] tally;
    logic [7:0] cycle;
    logic [7:0] shadow;
    logic shadow_full;
    logic load;
    logic [31:0] rdata;
  } tmirq_state_t;

  tmirq_state_t st;
  tmirq_state_t next_st;
  logic rst_meta_n;
  logic rst_sync_n;

  // only the release is synchronised; assertion stays asynchronous
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [31:0] tmirq_fit(input logic [1:0] mode,
                                            input logic [31:0] val);
    logic [31:0] r;
    r = val;
    if (mode == tmirq_pkg::MODE_8) begin
      r = {24'h00_0000, val[7:0]};
    end else if (mode != tmirq_pkg::MODE_32) begin
      r = {16'h0000, val[15:0]};
    end
    return r;
  endfunction : tmirq_fit

  function automatic logic tmirq_hit(input logic [7:0] a,
                                     input logic [7:0] ofs,
                                     input logic stb);
    return stb && (a == ofs);
  endfunction : tmirq_hit

  ////////////////////////////////////////////////////////////////////////
  // next state

  logic [1:0] mode;
  logic [7:0] status;
  logic [7:0] set_ev;
  logic [7:0] clr_ev;
  logic [1:0] cap_mode;
  logic [1:0] cap_ok;
  logic w_ok;
  logic sync_done;
  logic start_sync;

  always_comb begin
    next_st = st;
    mode = st.ctrl[tmirq_pkg::C_MODE_LO +: 2];
    cap_mode = {st.ctrl[tmirq_pkg::C_CAP1], st.ctrl[tmirq_pkg::C_CAP0]};
    // guarded registers ignore writes while the guard is active
    w_ok = wr_stb && !write_guard; // [RULE17]
    set_ev = 8'h00;
    clr_ev = 8'h00;
    sync_done = 1'b0;
    start_sync = 1'b0;
    next_st.load = 1'b0;

    // a capture while the channel flag is still up has nowhere to go
    cap_ok = capture_hit & ~st.flags[tmirq_pkg::B_CH1:tmirq_pkg::B_CH0];
    if ((capture_hit & st.flags[tmirq_pkg::B_CH1:tmirq_pkg::B_CH0]) != 2'b00)
    begin
      set_ev[tmirq_pkg::B_OVRN] = 1'b1; // [RULE8]
    end
    // flag register rises on the edge after the event: one cycle late
    set_ev[tmirq_pkg::B_CH0] = match_hit[0] | cap_ok[0]; // [RULE6]
    set_ev[tmirq_pkg::B_CH1] = match_hit[1] | cap_ok[1]; // [RULE6]
    set_ev[tmirq_pkg::B_WRAP] = wrap_hit; // [RULE10]

    // write-one-to-clear; flags have no write guard
    if (tmirq_hit(addr, tmirq_pkg::OFS_FLAGS, wr_stb)) begin
      clr_ev = wdata[7:0] & tmirq_pkg::IRQ_MASK; // [RULE7] [RULE9] [RULE11]
    end
    // capture register read clears the flag in capture operation
    clr_ev[tmirq_pkg::B_CH0] = clr_ev[tmirq_pkg::B_CH0] |
                               (capture_read[0] & cap_mode[0]); // [RULE7]
    clr_ev[tmirq_pkg::B_CH1] = clr_ev[tmirq_pkg::B_CH1] |
                               (capture_read[1] & cap_mode[1]); // [RULE7]

    // synchronisation engine: one pending write at a time
    case (st.sync_state)
      tmirq_pkg::TMIRQ_IDLE: begin
        next_st.sync_cnt = 8'h00;
      end
      tmirq_pkg::TMIRQ_SYNC: begin
        if (st.sync_cnt == 8'h01) begin
          sync_done = 1'b1;
          next_st.sync_state = tmirq_pkg::TMIRQ_IDLE;
          next_st.sync_cnt = 8'h00;
        end else begin
          next_st.sync_cnt = st.sync_cnt - 8'h01;
        end
      end
      default: begin
        next_st.sync_state = tmirq_pkg::TMIRQ_IDLE;
        next_st.sync_cnt = 8'h00;
      end
    endcase
    set_ev[tmirq_pkg::B_SRDY] = sync_done; // [RULE12]

    if (sync_done && st.pend_tally) begin
      next_st.load = 1'b1; // [RULE17]
      next_st.pend_tally = 1'b0;
    end
    if (sync_done && st.pend_cycle) begin
      next_st.shadow_full = 1'b1; // [RULE18]
      next_st.pend_cycle = 1'b0;
    end

    // writes that need synchronisation are refused while one is running
    if (st.sync_state == tmirq_pkg::TMIRQ_IDLE) begin
      if (tmirq_hit(addr, tmirq_pkg::OFS_TALLY, w_ok)) begin
        next_st.tally_wr = tmirq_fit(mode, wdata); // [RULE16] [RULE17]
        next_st.pend_tally = 1'b1;
        start_sync = 1'b1;
      end
      if (tmirq_hit(addr, tmirq_pkg::OFS_CYCLE, wr_stb)) begin
        next_st.shadow = wdata[7:0]; // [RULE18]
        next_st.shadow_full = 1'b0;
        next_st.pend_cycle = 1'b1;
        start_sync = 1'b1;
      end
    end
    if (start_sync) begin
      next_st.sync_state = tmirq_pkg::TMIRQ_SYNC; // [RULE13]
      next_st.sync_cnt = SYNC_LEN[7:0];
    end

    // set wins over clear for every hardware flag
    next_st.flags = ((st.flags & ~clr_ev) | set_ev) &
                    tmirq_pkg::IRQ_MASK; // [RULE5]

    // one shared enable state behind both set and clear views
    if (tmirq_hit(addr, tmirq_pkg::OFS_EN_SET, w_ok)) begin
      next_st.enables = st.enables |
                        (wdata[7:0] & tmirq_pkg::IRQ_MASK); // [RULE1] [RULE2] [RULE3]
    end
    if (tmirq_hit(addr, tmirq_pkg::OFS_EN_CLR, w_ok)) begin
      next_st.enables = st.enables & ~wdata[7:0]; // [RULE4]
    end

    if (tmirq_hit(addr, tmirq_pkg::OFS_CTRL, w_ok)) begin
      next_st.ctrl = wdata[7:0];
    end

    // stop state: disable, stop command or wrap in single-run mode
    if (!next_st.ctrl[tmirq_pkg::C_ENABLE]) begin
      next_st.halted = 1'b1; // [RULE15]
    end else if (tmirq_hit(addr, tmirq_pkg::OFS_CMD, w_ok) &&
                 wdata[tmirq_pkg::K_STOP]) begin
      next_st.halted = 1'b1; // [RULE15]
    end else if (wrap_hit && st.ctrl[tmirq_pkg::C_SINGLE]) begin
      next_st.halted = 1'b1; // [RULE15]
    end else if (tmirq_hit(addr, tmirq_pkg::OFS_CMD, w_ok) &&
                 wdata[tmirq_pkg::K_START]) begin
      next_st.halted = 1'b0;
    end else if (!st.ctrl[tmirq_pkg::C_ENABLE]) begin
      // enabling starts the counter
      next_st.halted = 1'b0;
    end

    // update condition: the wrap moves a synchronised shadow into place
    if (wrap_hit && st.shadow_full) begin
      next_st.cycle = st.shadow; // [RULE18]
      next_st.shadow_full = 1'b0;
    end

    // read copy follows the engine, trimmed to the mode width
    next_st.tally = tmirq_fit(mode, live_count); // [RULE16] [RULE17]

    status = 8'h00;
    status[tmirq_pkg::S_BUSY] =
      (st.sync_state == tmirq_pkg::TMIRQ_SYNC); // [RULE13]
    status[tmirq_pkg::S_UPPER32] = IS_UPPER & lower_is_32; // [RULE14]
    status[tmirq_pkg::S_STOP] = st.halted; // [RULE15]

    // read data stand in the cycle after the strobe only
    next_st.rdata = 32'h0000_0000;
    if (rd_stb) begin
      case (addr)
        tmirq_pkg::OFS_CTRL: next_st.rdata = {24'h00_0000, st.ctrl};
        tmirq_pkg::OFS_EN_CLR: next_st.rdata = {24'h00_0000, st.enables};
        tmirq_pkg::OFS_EN_SET: next_st.rdata = {24'h00_0000, st.enables};
        tmirq_pkg::OFS_FLAGS: next_st.rdata = {24'h00_0000, st.flags};
        tmirq_pkg::OFS_STATUS: next_st.rdata = {24'h00_0000, status};
        tmirq_pkg::OFS_TALLY: next_st.rdata = st.tally;
        tmirq_pkg::OFS_CYCLE: next_st.rdata = {24'h00_0000, st.cycle};
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st.enables <= tmirq_pkg::RST_EN;
      st.flags <= tmirq_pkg::RST_FLAGS; // [RULE5]
      st.ctrl <= tmirq_pkg::RST_CTRL;
      st.halted <= tmirq_pkg::RST_STATUS[tmirq_pkg::S_STOP]; // [RULE13]
      st.sync_state <= tmirq_pkg::TMIRQ_IDLE;
      st.sync_cnt <= 8'h00;
      st.pend_tally <= 1'b0;
      st.pend_cycle <= 1'b0;
      st.tally_wr <= tmirq_pkg::RST_TALLY;
      st.tally <= tmirq_pkg::RST_TALLY; // [RULE16]
      st.cycle <= tmirq_pkg::RST_CYCLE; // [RULE18]
      st.shadow <= tmirq_pkg::RST_CYCLE;
      st.shadow_full <= 1'b0;
      st.load <= 1'b0;
      st.rdata <= 32'h0000_0000;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign rdata = st.rdata;
  assign capture_store = capture_hit &
                         ~st.flags[tmirq_pkg::B_CH1:tmirq_pkg::B_CH0]; // [RULE8]
  assign counter_run = !st.halted;
  assign counter_mode = st.ctrl[tmirq_pkg::C_MODE_LO +: 2];
  assign cycle_length = st.cycle;
  assign tally_load = st.load;
  assign tally_load_value = st.tally_wr;
  assign irq = |(st.flags & st.enables); // [RULE6] [RULE10] [RULE12]

endmodule : tmirq_top

// file: tb/tmirq_checker.sv
// port assertions for the timer interrupt/status block
`timescale 1ns/10ps
module tmirq_checker #(
  parameter int SYNC_LEN = 4,
  parameter bit IS_UPPER = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [31:0] rdata,
  input wire logic write_guard,
  input wire logic [1:0] capture_hit,
  input wire logic wrap_hit,
  input wire logic lower_is_32,
  input wire logic [1:0] capture_store,
  input wire logic counter_run,
  input wire logic [7:0] cycle_length,
  input wire logic tally_load,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic tally_wr;
  logic cmd_stop;
  assign tally_wr = wr_stb && addr == tmirq_pkg::OFS_TALLY;
  assign cmd_stop = wr_stb && addr == tmirq_pkg::OFS_CMD && wdata[1];
  ////////////////////////////////////////
  chk_rdata_idle: assert property (!$past(rd_stb) |-> rdata == 32'h0)
    else $error("rdata not zero outside a read");
  chk_unmapped_zero: assert property (rd_stb && addr == 8'h08 |=>
    rdata == 32'h0) else $error("unmapped read not zero");
  chk_overrun_block: assert property (capture_hit[1] && capture_store[1] ##2
    capture_hit[1] |-> !capture_store[1])
    else $error("capture stored over a set flag");
  chk_load_pulse: assert property (tally_load |=> !tally_load)
    else $error("tally load longer than one cycle");
  chk_load_sync: assert property ($rose(tally_load) |->
    $past(tally_wr, SYNC_LEN + 1))
    else $error("tally load without synced write");
  chk_cycle_wrap: assert property ($changed(cycle_length) |->
    $past(wrap_hit))
    else $error("period changed without update");
  chk_stop_cmd: assert property (cmd_stop && !write_guard |=>
    !counter_run)
    else $error("stop command left counter running");
  chk_status_upper: assert property (rd_stb && addr == tmirq_pkg::OFS_STATUS
    |=> rdata[4] == (IS_UPPER && $past(lower_is_32)))
    else $error("upper-unit status bit wrong");
  chk_status_stop: assert property (rd_stb && addr == tmirq_pkg::OFS_STATUS
    |=> rdata[3] == !$past(counter_run))
    else $error("stop status disagrees with run");
  cover property ($rose(tally_load));
  cover property ($rose(irq));
  cover property ($changed(cycle_length));
endmodule : tmirq_checker
bind tmirq_top tmirq_checker #(.SYNC_LEN(SYNC_LEN), .IS_UPPER(IS_UPPER))
  tmirq_checker_inst (.clk, .rst_n, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
  .write_guard, .capture_hit, .wrap_hit, .lower_is_32, .capture_store,
  .counter_run, .cycle_length, .tally_load, .irq);

// file: tb/tmirq_top_tb.sv
// self-checking bench for the timer interrupt/status block
`timescale 1ns/10ps
module tmirq_top_tb;
  localparam int SL = 2;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic write_guard = 1'b0;
  logic [1:0] match_hit = 2'h0;
  logic [1:0] capture_hit = 2'h0;
  logic [1:0] capture_read = 2'h0;
  logic wrap_hit = 1'b0;
  logic [31:0] live_count = 32'h1234_5678;
  logic lower_is_32 = 1'b0;
  logic [31:0] rdata, tally_load_value, d;
  logic [1:0] capture_store, counter_mode;
  logic [7:0] cycle_length;
  logic counter_run, tally_load, irq;
  int n_fail = 0;
  int compares = 0;
  int i;
  tmirq_top #(.SYNC_LEN(SL), .IS_UPPER(1'b1)) tmirq_top_inst (.clk, .rst_n,
    .addr, .wdata, .wr_stb, .rd_stb, .rdata, .write_guard, .match_hit,
    .capture_hit, .capture_read, .wrap_hit, .live_count, .lower_is_32,
    .capture_store, .counter_run, .counter_mode, .cycle_length, .tally_load,
    .tally_load_value, .irq);
  initial begin
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rd
  task ev(input logic [1:0] m, c, r, input logic w);
    @(posedge clk);
    match_hit <= m;
    capture_hit <= c;
    capture_read <= r;
    wrap_hit <= w;
    @(posedge clk);
    {match_hit, capture_hit, capture_read, wrap_hit} <= 7'h0;
    #1;
  endtask : ev
  task report_and_stop;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    #200000;
    n_fail++;
    report_and_stop();
  end
  ////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(8'h0e, 32'h0);
    rd(8'h0f, 32'h08);
    rd(8'h10, 32'h5678);
    rd(8'h14, 32'hff);
    rd(8'h08, 32'h0);
    d = 32'h0;
    for (i = 0; i < 6; i++) begin
      if (i != 2) begin
        wr(8'h0d, 32'h0);
        wr(8'h0d, 32'h1 << i);
        d = d | (32'h1 << i);
        rd(8'h0c, d);
      end
    end
    wr(8'h0c, 32'h11);
    rd(8'h0d, 32'h2a);
    wr(8'h0d, 32'h3b);
    ev(2'h0, 2'h0, 2'h0, 1'b1);
    rd(8'h0e, 32'h1);
    chk(32'(irq), 32'h1);
    wr(8'h0e, 32'h0);
    rd(8'h0e, 32'h1);
    wr(8'h0e, 32'h1);
    rd(8'h0e, 32'h0);
    ev(2'h1, 2'h0, 2'h0, 1'b0);
    rd(8'h0e, 32'h10);
    wr(8'h0e, 32'h10);
    rd(8'h0e, 32'h0);
    // channel 1 in capture mode: the second capture must overrun
    wr(8'h00, 32'h20);
    ev(2'h0, 2'h2, 2'h0, 1'b0);
    ev(2'h0, 2'h2, 2'h0, 1'b0);
    rd(8'h0e, 32'h22);
    ev(2'h0, 2'h0, 2'h2, 1'b0);
    rd(8'h0e, 32'h02);
    wr(8'h0e, 32'h02);
    rd(8'h0e, 32'h0);
    wr(8'h0c, 32'h3b);
    ev(2'h0, 2'h0, 2'h0, 1'b1);
    chk(32'(irq), 32'h0);
    wr(8'h0e, 32'h1);
    wr(8'h00, 32'h02);
    rd(8'h10, 32'h78);
    chk(32'(counter_mode), 32'h1);
    wr(8'h10, 32'h0000_01a5);
    rd(8'h0f, 32'h88);
    chk(32'(tally_load), 32'h1);
    chk(tally_load_value, 32'ha5);
    rd(8'h0e, 32'h08);
    wr(8'h0e, 32'h08);
    write_guard <= 1'b1;
    wr(8'h10, 32'h33);
    d = 32'h0;
    for (i = 0; i < SL + 4; i++) begin
      @(posedge clk);
      #1;
      d = d | 32'(tally_load);
    end
    chk(d, 32'h0);
    write_guard <= 1'b0;
    wr(8'h14, 32'h40);
    repeat (SL + 2) @(posedge clk);
    ev(2'h0, 2'h0, 2'h0, 1'b1);
    chk(32'(cycle_length), 32'h40);
    wr(8'h0e, 32'h09);
    wr(8'h00, 32'h03);
    rd(8'h0f, 32'h00);
    lower_is_32 <= 1'b1;
    rd(8'h0f, 32'h10);
    wr(8'h04, 32'h2);
    rd(8'h0f, 32'h18);
    wr(8'h00, 32'h0b);
    wr(8'h04, 32'h1);
    rd(8'h0f, 32'h10);
    ev(2'h0, 2'h0, 2'h0, 1'b1);
    rd(8'h0f, 32'h18);
    report_and_stop();
  end
endmodule : tmirq_top_tb
